// >>> pkg/coo_pkg.sv
// Package for the charger option-one register bank: offsets, layout, reset and timing constants.
package coo_pkg;

	// Byte addresses of the two halves of the option register.
	localparam logic [7:0]  COO_ADDR_LOW      = 8'h30;
	localparam logic [7:0]  COO_ADDR_HIGH     = 8'h31;

	// Whole-register value after power-on.
	localparam logic [15:0] COO_RESET_VALUE   = 16'h0211;

	// High-byte field positions.
	localparam int          COO_HI_BATT_BUF   = 7;
	localparam int          COO_HI_THROT_MSB  = 6;
	localparam int          COO_HI_THROT_LSB  = 5;
	localparam int          COO_HI_PWR_EN     = 4;
	localparam int          COO_HI_IN_SHUNT   = 3;
	localparam int          COO_HI_CHG_SHUNT  = 2;
	localparam int          COO_HI_PWR_GAIN   = 1;

	// Low-byte field positions.
	localparam int          COO_LO_COMPARATOR_REF_SEL    = 7;
	localparam int          COO_LO_CMP_POL    = 6;
	localparam int          COO_LO_DEG_MSB    = 5;
	localparam int          COO_LO_DEG_LSB    = 4;
	localparam int          COO_LO_LATCHOFF   = 3;
	localparam int          COO_LO_SHIP       = 1;
	localparam int          COO_LO_WAKEUP     = 0;

	// Throttle source codes.
	localparam logic [1:0]  COO_THROT_OFF     = 2'h0;
	localparam logic [1:0]  COO_THROT_DCHG    = 2'h1;
	localparam logic [1:0]  COO_THROT_SYSTEM_VOLTAGE_SENSE    = 2'h2;

	// Comparator deglitch codes.
	localparam logic [1:0]  COO_DEG_OFF       = 2'h0;
	localparam logic [1:0]  COO_DEG_FAST      = 2'h1;
	localparam logic [1:0]  COO_DEG_MID       = 2'h2;

	// Clock rate and documented times in their own units.
	localparam longint      COO_CLK_HZ        = 10_000_000;
	localparam longint      COO_DEG_FAST_US   = 1;
	localparam longint      COO_DEG_MID_MS    = 2;
	localparam longint      COO_DEG_SLOW_S    = 5;
	localparam longint      COO_SHIP_MS       = 140;

	// Cycle counts derived from the times; all divide exactly at 10 MHz.
	localparam logic [31:0] COO_DEG_FAST_CYC  = 32'(COO_DEG_FAST_US * (COO_CLK_HZ / 1_000_000));
	localparam logic [31:0] COO_DEG_MID_CYC   = 32'(COO_DEG_MID_MS * (COO_CLK_HZ / 1_000));
	localparam logic [31:0] COO_DEG_SLOW_CYC  = 32'(COO_DEG_SLOW_S * COO_CLK_HZ);
	localparam logic [31:0] COO_SHIP_CYC      = 32'(COO_SHIP_MS * (COO_CLK_HZ / 1_000));

	// Decoded controls handed to the analog side.
	typedef struct packed {
		logic       battery_current_out_en;
		logic       system_power_out_en;
		logic       discharge_current_sense_en;
		logic       system_voltage_sense_en;
		logic       input_shunt_sel;
		logic       charge_shunt_sel;
		logic       power_monitor_gain;
		logic       comparator_ref_sel;
		logic       comparator_en;
		logic       force_latchoff;
		logic       auto_wakeup_en;
		logic       ship_discharge_on;
	} coo_ctrl_t;

	// Byte-wide register access request.
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} coo_req_t;

endpackage

// >>> verilog/coo_timer.sv
// One-shot cycle timer used to time the ship-mode discharge window.
`timescale 1ns/10ps

module coo_timer
	import coo_pkg::*;
#(
	parameter logic [31:0] CYCLES = COO_SHIP_CYC
) (
	// Clock and reset.
	input  wire logic ref_clk,
	input  wire logic rst_b,
	// Control.
	input  wire logic start,
	// Status.
	output logic      busy,
	output logic      done
);

	// All timer state in one word.
	typedef struct packed {
		logic [31:0] count;
		logic        busy;
		logic        done;
	} coo_timer_state_t;

	coo_timer_state_t st_q;	// Registered state.
	coo_timer_state_t st_d;	// Next state.

	// A start while running restarts the window, so a rewrite extends it.
	always_comb begin
		st_d      = st_q;
		st_d.done = 1'b0;
		if (start) begin
			st_d.busy  = 1'b1;
			st_d.count = CYCLES - 32'h0000_0001;
		end else if (st_q.busy) begin
			if (st_q.count == 32'h0000_0000) begin
				st_d.busy = 1'b0;
				st_d.done = 1'b1;
			end else begin
				st_d.count = st_q.count - 32'h0000_0001;
			end
		end
	end

	// State register.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign busy = st_q.busy;
	assign done = st_q.done;

	// Done follows the end of busy by no cycle of slack.
	a_done_ends_busy: assert property (@(posedge ref_clk) disable iff (!rst_b)
		done |-> !busy && $past(busy)) else $error("done without busy ending");

endmodule

// >>> verilog/coo_regs.sv
// Charger option-one register bank with its decoded controls and timers.
`timescale 1ns/10ps

// Function
// - Sixteen bits, high byte odd, reset 211h
// - Battery buffer enable, forced off in low-power
// - Bits 6-5 choose low-power throttle source
// - Power monitor enable, forced off in low-power
// - Bit 3 picks input shunt value
// - Bit 2 picks charge shunt value
// - Bit 1 picks power monitor gain
// - Low bit 7 picks comparator reference
// - Low bits 5-4 enable comparator, pick deglitch
// - Ship discharge runs 140 ms, then self-clears
module coo_regs
	import coo_pkg::*;
#(
	parameter logic [31:0] DEG_MID_CYC  = COO_DEG_MID_CYC,
	parameter logic [31:0] DEG_SLOW_CYC = COO_DEG_SLOW_CYC,
	parameter logic [31:0] SHIP_CYC     = COO_SHIP_CYC
) (
	// Clock and reset.
	input  wire logic      ref_clk,
	input  wire logic      rst_b,
	// Byte register port from the serial interface engine.
	input  wire coo_req_t  req,
	output logic [7:0]     rd_data,
	// Mode from the other option register.
	input  wire logic      low_power_mode,
	// Raw comparator level from the analog side, asynchronous.
	input  wire logic      comparator_raw,
	// Controls to the analog side.
	output coo_ctrl_t      ctrl,
	output logic           comparator_out
);

	// All bank state in one word.
	typedef struct packed {
		logic [15:0] regs;
		logic [7:0]  rd_data;
		logic [2:0]  cmp_sync;
		logic        cmp_out;
		logic [31:0] deg_count;
	} coo_state_t;

	coo_state_t st_q;	// Registered state.
	coo_state_t st_d;	// Next state.
	logic       ship_start;	// Host wrote a one to the ship bit.
	logic       ship_busy;	// Discharge window is running.
	logic       ship_done;	// Discharge window just ended.
	logic       cmp_level;	// Synchronised comparator level, polarity applied.
	logic [31:0] deg_limit;	// Falling-edge deglitch length for the chosen code.

	// Maps a deglitch code to its cycle count; the off code yields zero.
	function automatic logic [31:0] deg_cycles(input logic [1:0] code);
		case (code)
			COO_DEG_OFF:  deg_cycles = 32'h0000_0000;
			COO_DEG_FAST: deg_cycles = COO_DEG_FAST_CYC;
			COO_DEG_MID:  deg_cycles = DEG_MID_CYC;
			default:      deg_cycles = DEG_SLOW_CYC;
		endcase
	endfunction

	// A host write of one to the ship bit starts or restarts the window.
	assign ship_start = req.wr && (req.addr == COO_ADDR_LOW) && req.wdata[COO_LO_SHIP];

	// The comparator is only trusted once the second and third stages agree.
	assign cmp_level = (st_q.cmp_sync[2] == st_q.cmp_sync[1])
		? (st_q.cmp_sync[2] ^ st_q.regs[COO_LO_CMP_POL])
		: st_q.cmp_out;
	assign deg_limit = deg_cycles(st_q.regs[COO_LO_DEG_MSB:COO_LO_DEG_LSB]);

	// Next-state logic for the register, read data and comparator filter.
	always_comb begin
		st_d          = st_q;
		st_d.cmp_sync = {st_q.cmp_sync[1:0], comparator_raw};
		// Byte writes land in their own half; reserved bits store as written.
		if (req.wr && (req.addr == COO_ADDR_HIGH)) begin
			st_d.regs[15:8] = req.wdata;
		end
		if (req.wr && (req.addr == COO_ADDR_LOW)) begin
			st_d.regs[7:0] = req.wdata;
		end
		// The window end clears the ship bit unless a new one is written now.
		if (ship_done && !ship_start) begin
			st_d.regs[COO_LO_SHIP] = 1'b0;
		end
		// Reads answer from a register; other addresses read zero.
		if (req.rd) begin
			case (req.addr)
				COO_ADDR_HIGH: st_d.rd_data = st_q.regs[15:8];
				COO_ADDR_LOW:  st_d.rd_data = st_q.regs[7:0];
				default:       st_d.rd_data = 8'h00;
			endcase
		end
		// Rising output passes at once; a fall must stand for the deglitch time.
		if (deg_limit == 32'h0000_0000) begin
			st_d.cmp_out   = 1'b1;
			st_d.deg_count = 32'h0000_0000;
		end else if (cmp_level) begin
			st_d.cmp_out   = 1'b1;
			st_d.deg_count = 32'h0000_0000;
		end else if (st_q.cmp_out) begin
			if (st_q.deg_count >= deg_limit - 32'h0000_0001) begin
				st_d.cmp_out   = 1'b0;
				st_d.deg_count = 32'h0000_0000;
			end else begin
				st_d.deg_count = st_q.deg_count + 32'h0000_0001;
			end
		end
	end

	// State register; the option word takes its power-on value.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q      <= '0;
			st_q.regs <= COO_RESET_VALUE;
		end else begin
			st_q <= st_d;
		end
	end

	// Ship-mode discharge window timer.
	coo_timer #(
		.CYCLES (SHIP_CYC)
	) coo_timer_i (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.start   (ship_start),
		.busy    (ship_busy),
		.done    (ship_done)
	);

	// Decode of the stored fields onto the analog controls.
	always_comb begin
		ctrl = '0;
		// Low-power mode overrides both monitor enables.
		ctrl.battery_current_out_en = st_q.regs[8 + COO_HI_BATT_BUF] && !low_power_mode;
		ctrl.system_power_out_en    = st_q.regs[8 + COO_HI_PWR_EN] && !low_power_mode;
		// The reserved throttle code selects neither source.
		ctrl.discharge_current_sense_en =
			st_q.regs[8 + COO_HI_THROT_MSB:8 + COO_HI_THROT_LSB] == COO_THROT_DCHG;
		ctrl.system_voltage_sense_en =
			st_q.regs[8 + COO_HI_THROT_MSB:8 + COO_HI_THROT_LSB] == COO_THROT_SYSTEM_VOLTAGE_SENSE;
		ctrl.input_shunt_sel    = st_q.regs[8 + COO_HI_IN_SHUNT];
		ctrl.charge_shunt_sel   = st_q.regs[8 + COO_HI_CHG_SHUNT];
		ctrl.power_monitor_gain = st_q.regs[8 + COO_HI_PWR_GAIN];
		ctrl.comparator_ref_sel = st_q.regs[COO_LO_COMPARATOR_REF_SEL];
		ctrl.comparator_en      =
			st_q.regs[COO_LO_DEG_MSB:COO_LO_DEG_LSB] != COO_DEG_OFF;
		ctrl.force_latchoff     = st_q.regs[COO_LO_LATCHOFF];
		ctrl.auto_wakeup_en     = st_q.regs[COO_LO_WAKEUP];
		ctrl.ship_discharge_on  = ship_busy;
	end

	assign rd_data        = st_q.rd_data;
	assign comparator_out = st_q.cmp_out;

	// Low-power mode must hold both monitor buffers off.
	a_lpm_forces_off: assert property (@(posedge ref_clk) disable iff (!rst_b)
		low_power_mode |-> !ctrl.battery_current_out_en && !ctrl.system_power_out_en)
		else $error("monitor buffer on in low-power mode");

	// Monitor enable follows the high-byte bit one cycle after a write.
	a_pwr_en_write: assert property (@(posedge ref_clk) disable iff (!rst_b)
		req.wr && req.addr == COO_ADDR_HIGH && !low_power_mode ##1 !low_power_mode
		|-> ctrl.system_power_out_en == $past(req.wdata[COO_HI_PWR_EN]))
		else $error("power monitor enable not following write");

	// Battery buffer enable follows the high-byte bit one cycle after a write.
	a_batt_buf_write: assert property (@(posedge ref_clk) disable iff (!rst_b)
		req.wr && req.addr == COO_ADDR_HIGH && !low_power_mode ##1 !low_power_mode
		|-> ctrl.battery_current_out_en == $past(req.wdata[COO_HI_BATT_BUF]))
		else $error("battery buffer enable not following write");

	// High-byte write lands in the high half of the word.
	a_high_byte_write: assert property (@(posedge ref_clk) disable iff (!rst_b)
		req.wr && req.addr == COO_ADDR_HIGH |=> st_q.regs[15:8] == $past(req.wdata))
		else $error("high byte not stored");

	// Read of the even address returns the low half one cycle later.
	a_low_byte_read: assert property (@(posedge ref_clk) disable iff (!rst_b)
		req.rd && req.addr == COO_ADDR_LOW && !req.wr |=> rd_data == $past(st_q.regs[7:0]))
		else $error("low byte read mismatch");

	// Throttle sources are never both selected.
	a_throttle_onehot: assert property (@(posedge ref_clk) disable iff (!rst_b)
		!(ctrl.discharge_current_sense_en && ctrl.system_voltage_sense_en))
		else $error("both throttle sources selected");

	// Shunt and gain selects mirror their stored bits.
	a_select_mirror: assert property (@(posedge ref_clk) disable iff (!rst_b)
		req.wr && req.addr == COO_ADDR_HIGH |=> ctrl.input_shunt_sel ==
		$past(req.wdata[COO_HI_IN_SHUNT]) && ctrl.charge_shunt_sel ==
		$past(req.wdata[COO_HI_CHG_SHUNT]) && ctrl.power_monitor_gain ==
		$past(req.wdata[COO_HI_PWR_GAIN])) else $error("select not stored");

	// Reference select follows a low-byte write.
	a_ref_sel_write: assert property (@(posedge ref_clk) disable iff (!rst_b)
		req.wr && req.addr == COO_ADDR_LOW |=> ctrl.comparator_ref_sel ==
		$past(req.wdata[COO_LO_COMPARATOR_REF_SEL])) else $error("reference select not stored");

	// Disabled comparator holds its output high.
	a_cmp_off_high: assert property (@(posedge ref_clk) disable iff (!rst_b)
		!ctrl.comparator_en ##1 !ctrl.comparator_en |-> comparator_out)
		else $error("disabled comparator output low");

	// Only falls are deglitched, so a trusted high level must raise the output at once.
	a_cmp_rise_fast: assert property (@(posedge ref_clk) disable iff (!rst_b)
		ctrl.comparator_en && cmp_level |=> comparator_out)
		else $error("comparator output did not rise");

	// The ship window begins the cycle after the bit is written to one.
	a_ship_starts: assert property (@(posedge ref_clk) disable iff (!rst_b)
		ship_start |=> ctrl.ship_discharge_on && st_q.regs[COO_LO_SHIP])
		else $error("ship discharge did not start");

	// When the window ends the bit clears unless rewritten.
	a_ship_clears: assert property (@(posedge ref_clk) disable iff (!rst_b)
		ship_done && !ship_start |=> !st_q.regs[COO_LO_SHIP])
		else $error("ship bit not cleared");

endmodule

// >>> test/coo_host.sv
// Host controller model that drives the byte register port.
`timescale 1ns/10ps

module coo_host
	import coo_pkg::*;
(
	// Clock.
	input  wire logic       ref_clk,
	// Board state seen by the host.
	input  wire logic       adapter_present,
	// Byte register port.
	output coo_req_t        req,
	input  wire logic [7:0] rd_data
);
	// The port is idle from time zero.
	initial begin
		req = '0;
	end

	// Drops the strobes; released lines flip so stale values never look valid.
	task automatic release_port();
		req.wr = 1'b0;
		req.rd = 1'b0;
		req.addr = ~req.addr;
		req.wdata = ~req.wdata;
	endtask

	// One byte write, held across exactly one rising edge.
	task automatic wr(input logic [7:0] addr, input logic [7:0] data);
		logic [7:0] d;
		d = data;
		if (addr == COO_ADDR_HIGH) begin
			d[0] = 1'b0;
			if (adapter_present) begin
				d[6:5] = COO_THROT_OFF;
			end
		end
		if (addr == COO_ADDR_LOW) begin
			d[2] = 1'b0;
		end
		@(negedge ref_clk);
		req.addr = addr;
		req.wdata = d;
		req.wr = 1'b1;
		@(negedge ref_clk);
		release_port();
	endtask

	// One byte read; the data is taken after the accepting edge has landed.
	task automatic rd(input logic [7:0] addr, output logic [7:0] data);
		@(negedge ref_clk);
		req.addr = addr;
		req.rd = 1'b1;
		@(negedge ref_clk);
		data = rd_data;
		release_port();
	endtask
endmodule

// >>> test/test_coo_regs.sv
// Self-checking bench for the charger option-one register bank.
`timescale 1ns/10ps

module test_coo_regs
	import coo_pkg::*;
;
	// One table row: a byte write and the mode level it is made under.
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
		logic       lpm;
	} coo_row_t;

	logic       ref_clk = 1'b0;    // Clock.
	logic       rst_b   = 1'b0;    // Reset, held at start.
	logic       lpm     = 1'b0;    // Low-power mode level.
	logic       cmp_raw = 1'b0;    // Raw comparator input.
	coo_req_t   req;               // Port driven by the host model.
	logic [7:0] rd_data;           // Read data.
	coo_ctrl_t  ctrl;              // Decoded controls.
	logic       cmp_out;           // Filtered comparator output.
	logic [7:0] hi = 8'h02;        // Shadow high byte.
	logic [7:0] lo = 8'h11;        // Shadow low byte.
	logic [7:0] got;               // Last read byte.
	int         failures = 0;      // Mismatch count.
	int         check_count = 0;   // Comparison count.
	int         ship_cnt = 0;      // Cycles the discharge window stood.
	coo_row_t   rows [14] = '{'{8'h31, 8'h80, 1'b0}, '{8'h31, 8'h80, 1'b1},
		'{8'h31, 8'h10, 1'b0}, '{8'h31, 8'h10, 1'b1}, '{8'h31, 8'h20, 1'b0},
		'{8'h31, 8'h40, 1'b0}, '{8'h31, 8'h60, 1'b0}, '{8'h31, 8'h0C, 1'b0},
		'{8'h31, 8'hFE, 1'b1}, '{8'h30, 8'h80, 1'b0}, '{8'h30, 8'h00, 1'b0},
		'{8'h30, 8'h20, 1'b0}, '{8'h30, 8'h39, 1'b0}, '{8'h32, 8'hAA, 1'b0}};
	int         deg [3] = '{10, 20, 40};  // Deglitch cycles of codes 1 to 3.

	// Clock at 10 MHz.
	always #50 ref_clk = ~ref_clk;

	// Counts every cycle in which the discharge window is open.
	always @(negedge ref_clk) begin
		if (ctrl.ship_discharge_on === 1'b1) begin
			ship_cnt++;
		end
	end

	// Device with short counts so the run stays brief.
	coo_regs #(.DEG_MID_CYC(32'h0000_0014), .DEG_SLOW_CYC(32'h0000_0028),
		.SHIP_CYC(32'h0000_0010)) coo_regs_i (.ref_clk(ref_clk), .rst_b(rst_b),
		.req(req), .rd_data(rd_data), .low_power_mode(lpm), .comparator_raw(cmp_raw),
		.ctrl(ctrl), .comparator_out(cmp_out));

	// Host on the far side of the register port.
	coo_host coo_host_i (.ref_clk(ref_clk), .adapter_present(1'b0), .req(req),
		.rd_data(rd_data));

	// Expected controls worked out from the field layout.
	function automatic coo_ctrl_t exp_ctrl(logic [7:0] h, logic [7:0] l, logic m);
		return {h[7] & ~m, h[4] & ~m, h[6:5] == 2'h1, h[6:5] == 2'h2, h[3], h[2], h[1],
			l[7], l[5:4] != 2'h0, l[3], l[0], 1'b0};
	endfunction

	// Compares one value and reports a mismatch at once.
	task automatic check(input logic [15:0] g, input logic [15:0] e);
		check_count++;
		if (g !== e) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Reads both halves back and checks them and the controls against the power-on word.
	task automatic check_reset_values();
		hi = 8'h02;
		lo = 8'h11;
		coo_host_i.rd(COO_ADDR_HIGH, got);
		check(got, 16'h0002);
		coo_host_i.rd(COO_ADDR_LOW, got);
		check(got, 16'h0011);
		check(ctrl, exp_ctrl(hi, lo, lpm));
	endtask

	// Cuts a hang short well beyond the expected run length.
	initial begin
		#2_000_000;
		failures++;
		print_verdict();
	end

	// Main sequence.
	initial begin
		repeat (16) @(negedge ref_clk);
		rst_b = 1'b1;
		check_reset_values();
		$display("Test reset done");
		for (int i = 0; i < 14; i++) begin
			lpm = rows[i].lpm;
			coo_host_i.wr(rows[i].addr, rows[i].data);
			if (rows[i].addr == COO_ADDR_HIGH) begin
				hi = rows[i].data;
			end else if (rows[i].addr == COO_ADDR_LOW) begin
				lo = rows[i].data;
			end
			coo_host_i.rd(rows[i].addr, got);
			check(got, (rows[i].addr[7:1] == 7'h18) ? rows[i].data : 8'h00);
			check(ctrl, exp_ctrl(hi, lo, lpm));
		end
		$display("Test table done");
		// A reset in mid-run must bring the whole word back to its power-on value.
		rst_b = 1'b0;
		repeat (2) @(negedge ref_clk);
		rst_b = 1'b1;
		check_reset_values();
		$display("Test mid-run reset done");
		// A zero written mid-window does not shorten it.
		ship_cnt = 0;
		coo_host_i.wr(COO_ADDR_LOW, 8'h13);
		check(ctrl.ship_discharge_on, 16'h0001);
		repeat (6) @(negedge ref_clk);
		coo_host_i.wr(COO_ADDR_LOW, 8'h11);
		for (int n = 0; n < 100 && ctrl.ship_discharge_on !== 1'b0; n++) @(negedge ref_clk);
		check(16'(ship_cnt), 16'h0010);
		coo_host_i.rd(COO_ADDR_LOW, got);
		check(got, 16'h0011);
		// A second set restarts the full window.
		ship_cnt = 0;
		coo_host_i.wr(COO_ADDR_LOW, 8'h13);
		repeat (6) @(negedge ref_clk);
		coo_host_i.wr(COO_ADDR_LOW, 8'h13);
		for (int n = 0; n < 100 && ctrl.ship_discharge_on !== 1'b0; n++) @(negedge ref_clk);
		check(16'(ship_cnt), 16'h0018);
		coo_host_i.rd(COO_ADDR_LOW, got);
		check(got, 16'h0011);
		$display("Test discharge done");
		// Each enabled code holds a falling output for its own deglitch time.
		for (int c = 1; c < 4; c++) begin
			// With polarity zero a high raw level drives the output high.
			cmp_raw = 1'b1;
			coo_host_i.wr(COO_ADDR_LOW, 8'(c << 4) | 8'h01);
			repeat (5) @(negedge ref_clk);
			check(cmp_out, 16'h0001);
			cmp_raw = 1'b0;
			repeat (deg[c - 1]) @(negedge ref_clk);
			check(cmp_out, 16'h0001);
			repeat (15) @(negedge ref_clk);
			check(cmp_out, 16'h0000);
		end
		// The disabled code releases the output although the raw level is low.
		coo_host_i.wr(COO_ADDR_LOW, 8'h01);
		repeat (60) @(negedge ref_clk);
		check(cmp_out, 16'h0001);
		$display("Test comparator done");
		print_verdict();
	end
endmodule
